// ---- hdl/dsac_defines.svh ----
// Constants for the delta-sigma conversion control block.
// Assumes inclusion by bare name from the design files.
`ifndef DSAC_DEFINES_SVH
`define DSAC_DEFINES_SVH
`define DSAC_MODE_W        2
`define DSAC_MODE_SINGLE   2'h0
`define DSAC_MODE_CONT     2'h1
`define DSAC_MODE_MULTI    2'h2
`define DSAC_MODE_TURBO    2'h3
`define DSAC_RES_W         5
`define DSAC_RES_MIN       5'h08
`define DSAC_RES_NOM       5'h10
`define DSAC_RES_MAX       5'h14
`define DSAC_RES_TURBO_LO  5'h11
`define DSAC_PIPE_DEPTH    4
`define DSAC_PRIME_CNT     3'h3
`define DSAC_DATA_W        20
`define DSAC_CNT_W         22
`define DSAC_TURBO_SAMPLES 3'h4
`endif

// ---- hdl/dsac_pkg.sv ----
// Types for the delta-sigma conversion control block.
// Assumes dsac_defines.svh is on the include path.
`default_nettype none
`include "dsac_defines.svh"
package dsac_pkg;
  typedef logic [`DSAC_MODE_W-1:0] dsac_mode_t;
  typedef logic [`DSAC_RES_W-1:0]  dsac_res_t;
  typedef logic [`DSAC_DATA_W-1:0] dsac_data_t;
  typedef enum logic [2:0] {
    DSAC_IDLE,
    DSAC_PRIME,
    DSAC_CONV,
    DSAC_HOLD
  } dsac_state_e;
endpackage
`default_nettype wire

// ---- hdl/dsac_decim.sv ----
// Pipelined decimator: integrates the modulator bit over one conversion
// period and sums the last four period values into one result.
// Assumes period_done from the sequencer marks each period end.
`default_nettype none
`include "dsac_defines.svh"
module dsac_decim
  import dsac_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_sys_rst,
  // Control
  input  wire logic                   i_clear,
  input  wire logic                   i_bit_en,
  input  wire logic                   i_mod_bit,
  input  wire logic                   i_period_done,
  input  wire dsac_res_t              i_res,
  // Result
  output logic [`DSAC_DATA_W-1:0]     o_result
);
  logic [`DSAC_CNT_W-1:0] acc_q;
  logic [`DSAC_CNT_W-1:0] stage_q [`DSAC_PIPE_DEPTH];
  logic [`DSAC_CNT_W+1:0] sum;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_q <= '0;
    end else if (i_clear || i_period_done) begin
      acc_q <= '0;
    end else if (i_bit_en && i_mod_bit) begin
      acc_q <= acc_q + 1'b1;
    end
  end

  // Four-deep history of period sums
  genvar g;
  generate
    for (g = 0; g < `DSAC_PIPE_DEPTH; g++) begin : g_stage
      always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          stage_q[g] <= '0;
        end else if (i_clear) begin
          stage_q[g] <= '0;
        end else if (i_period_done) begin
          stage_q[g] <= (g == 0) ? acc_q : stage_q[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  always_comb begin
    sum = {2'b00, stage_q[0]} + {2'b00, stage_q[1]} + {2'b00, stage_q[2]}
        + {2'b00, stage_q[3]};
  end

  // Result scaled to the configured resolution by dropping low bits
  always_comb begin
    o_result = sum[`DSAC_CNT_W+1 -: `DSAC_DATA_W] >> (`DSAC_RES_MAX - i_res);
  end
endmodule
`default_nettype wire

// ---- hdl/dsac_result.sv ----
// Result holding register with end-of-conversion flag.
// Assumes the reader acknowledges with a one-cycle read pulse.
`default_nettype none
`include "dsac_defines.svh"
module dsac_result
  import dsac_pkg::*;
(
  // Clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_sys_rst,
  // Capture and read
  input  wire logic               i_load,
  input  wire dsac_data_t         i_data,
  input  wire logic               i_read,
  // Outputs
  output dsac_data_t              o_data,
  output logic                    o_eoc
);
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_data <= '0;
    end else if (i_load) begin
      o_data <= i_data;
    end
  end

  // A new result in the read cycle keeps the flag set
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_eoc <= 1'b0;
    end else if (i_load) begin
      o_eoc <= 1'b1;
    end else if (i_read) begin
      o_eoc <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/dsac_ctrl.sv ----
// Conversion sequencer for a delta-sigma converter: modes, priming,
// start handling and result hand-off.
// Assumes modulator bit and start input are synchronous to i_ref_clk.
//
// Behaviour
// - Decimator output combines the four most recent period samples.
// - After input select change, results invalid until fourth sample completes.
// - Any mode starts on the start bit or the start input.
// - Completion sets status and raises end-of-conversion until result read.
// - Single mode idles in standby until a start event.
// - Single mode runs four conversions per start; three only prime.
// - Single mode signals a result only after the fourth conversion.
// - Single mode returns to standby once the result is read.
// - Continuous mode gives its first result after three priming periods.
// - Continuous mode then yields one result per period without new starts.
// - Multi mode resets the converter between samples.
// - Multi mode reprimes the decimator before every sample.
// - Multi mode launches the next sample automatically after completion.
// - Turbo mode at 8 to 16 bits behaves as multi mode.
// - Turbo mode at 17 to 20 bits resets only at conversion end.
// - Resolution up to 20 bits, nominal 16; more bits lengthen the period.
`default_nettype none
`include "dsac_defines.svh"
module dsac_ctrl
  import dsac_pkg::*;
(
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  // Configuration
  input  wire dsac_mode_t   i_mode,
  input  wire dsac_res_t    i_res,
  input  wire logic         i_enable,
  // Start sources
  input  wire logic         i_start_bit,
  input  wire logic         i_soc,
  // Modulator and input selection
  input  wire logic         i_mod_bit,
  input  wire logic         i_mux_change,
  // Result read
  input  wire logic         i_result_read,
  // Outputs
  output dsac_data_t        o_result,
  output logic              o_eoc,
  output logic              o_status_done,
  output logic              o_busy,
  output logic              o_data_valid,
  output logic              o_mod_reset
);
  dsac_state_e             state_q;
  dsac_mode_t              mode_q;
  dsac_res_t               res_q;
  logic [`DSAC_CNT_W-1:0]  per_cnt_q;
  logic [`DSAC_CNT_W-1:0]  per_len;
  logic [2:0]              prime_q;
  logic [2:0]              valid_cnt_q;
  logic [2:0]              turbo_q;
  logic                    soc_q;
  logic                    start_evt;
  logic                    period_done;
  logic                    clear_dec;
  logic                    load;
  logic                    turbo_long;
  dsac_data_t              dec_result;
  dsac_data_t              res_data;
  logic                    res_eoc;

  // Edge of the start input so a held level counts once
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      soc_q <= 1'b0;
    end else begin
      soc_q <= i_soc;
    end
  end

  always_comb begin
    start_evt = i_enable && (i_start_bit || (i_soc && !soc_q));
  end

  // Period length doubles per extra bit: 2^res clock cycles
  always_comb begin
    per_len = `DSAC_CNT_W'(1) << res_q;
  end

  always_comb begin
    period_done = (state_q != DSAC_IDLE) && (state_q != DSAC_HOLD)
               && (per_cnt_q == per_len - 1'b1);
    turbo_long  = (mode_q == `DSAC_MODE_TURBO) && (res_q >= `DSAC_RES_TURBO_LO);
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      per_cnt_q <= '0;
    end else if (state_q == DSAC_IDLE || state_q == DSAC_HOLD || period_done) begin
      per_cnt_q <= '0;
    end else begin
      per_cnt_q <= per_cnt_q + 1'b1;
    end
  end

  // Settings latched at start, held for the whole sequence
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_q <= `DSAC_MODE_SINGLE;
      res_q  <= `DSAC_RES_NOM;
    end else if (state_q == DSAC_IDLE && start_evt) begin
      mode_q <= i_mode;
      if (i_res < `DSAC_RES_MIN) begin
        res_q <= `DSAC_RES_MIN;
      end else if (i_res > `DSAC_RES_MAX) begin
        res_q <= `DSAC_RES_MAX;
      end else begin
        res_q <= i_res;
      end
    end
  end

  // Sequencer
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= DSAC_IDLE;
      prime_q <= '0;
      turbo_q <= '0;
    end else if (!i_enable) begin
      state_q <= DSAC_IDLE;
      prime_q <= '0;
      turbo_q <= '0;
    end else begin
      unique case (state_q)
        DSAC_IDLE: begin
          if (start_evt) begin
            state_q <= DSAC_PRIME;
            prime_q <= '0;
            turbo_q <= '0;
          end
        end
        DSAC_PRIME: begin
          // Three priming periods before the result period
          if (period_done) begin
            prime_q <= prime_q + 1'b1;
            if (prime_q == `DSAC_PRIME_CNT - 1'b1) begin
              state_q <= DSAC_CONV;
            end
          end
        end
        DSAC_CONV: begin
          if (period_done) begin
            unique case (mode_q)
              `DSAC_MODE_SINGLE: state_q <= DSAC_HOLD;
              `DSAC_MODE_CONT:   state_q <= DSAC_CONV;
              `DSAC_MODE_MULTI: begin
                state_q <= DSAC_PRIME;
                prime_q <= '0;
              end
              `DSAC_MODE_TURBO: begin
                if (turbo_long) begin
                  // Keep the pipeline full; reset only after the run
                  turbo_q <= turbo_q + 1'b1;
                  if (turbo_q == `DSAC_TURBO_SAMPLES - 1'b1) begin
                    state_q <= DSAC_PRIME;
                    prime_q <= '0;
                    turbo_q <= '0;
                  end
                end else begin
                  state_q <= DSAC_PRIME;
                  prime_q <= '0;
                end
              end
            endcase
          end
        end
        DSAC_HOLD: begin
          if (i_result_read || !res_eoc) begin
            state_q <= DSAC_IDLE;
          end
        end
        default: state_q <= DSAC_IDLE;
      endcase
    end
  end

  always_comb begin
    // The fourth completed period since a clear is the first valid one
    // A select change in the same cycle withholds the stale result
    load      = (state_q == DSAC_CONV) && period_done && (valid_cnt_q >= 3'h3)
             && !i_mux_change;
    clear_dec = (state_q == DSAC_IDLE)
             || ((state_q == DSAC_PRIME) && (prime_q == '0) && (per_cnt_q == '0));
  end

  // Count completed samples since a mux change or a clear
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      valid_cnt_q <= '0;
    end else if (i_mux_change || clear_dec) begin
      valid_cnt_q <= '0;
    end else if (period_done && valid_cnt_q != 3'h4) begin
      valid_cnt_q <= valid_cnt_q + 1'b1;
    end
  end

  dsac_decim u_decim (
    .i_ref_clk     (i_ref_clk),
    .i_sys_rst     (i_sys_rst),
    .i_clear       (clear_dec),
    .i_bit_en      (state_q == DSAC_PRIME || state_q == DSAC_CONV),
    .i_mod_bit     (i_mod_bit),
    .i_period_done (period_done),
    .i_res         (res_q),
    .o_result      (dec_result)
  );

  dsac_result u_result (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_load    (load),
    .i_data    (dec_result),
    .i_read    (i_result_read),
    .o_data    (res_data),
    .o_eoc     (res_eoc)
  );

  // Output registers; status mirrors the flag for polling
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_result      <= '0;
      o_eoc         <= 1'b0;
      o_status_done <= 1'b0;
      o_busy        <= 1'b0;
      o_data_valid  <= 1'b0;
      o_mod_reset   <= 1'b1;
    end else begin
      o_result      <= load ? dec_result : res_data;
      o_eoc         <= load || (res_eoc && !i_result_read);
      o_status_done <= load || (res_eoc && !i_result_read);
      o_busy        <= (state_q != DSAC_IDLE);
      // Valid rises with the first flagged result, not a cycle after it
      o_data_valid  <= ((valid_cnt_q == 3'h4) || (period_done && valid_cnt_q == 3'h3))
                    && !i_mux_change;
      o_mod_reset   <= clear_dec;
    end
  end
endmodule
`default_nettype wire

// ---- sim/dsac_ctrl_props.sv ----
// Port checker for the conversion sequencer.
// Assumes it is bound to dsac_ctrl and sees only that module's ports.
`default_nettype none
module dsac_ctrl_props
  import dsac_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Watched ports
  input wire logic i_enable,
  input wire logic i_start_bit,
  input wire logic i_mux_change,
  input wire logic i_result_read,
  input wire logic o_eoc,
  input wire logic o_status_done,
  input wire logic o_busy,
  input wire logic o_data_valid,
  input wire logic o_mod_reset
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_start;
    !o_busy && !o_eoc && i_enable && i_start_bit;
  endsequence
  // Priming periods are far longer than eight cycles
  sequence s_quiet;
    !o_eoc [*8];
  endsequence
  a_flag_pair: assert property (o_eoc == o_status_done)
    else $error("status bit and end flag differ");
  a_eoc_holds: assert property (o_eoc && i_enable && !i_result_read |=> o_eoc)
    else $error("end flag dropped before read");
  a_read_clears: assert property (o_eoc && i_result_read |=> !o_eoc)
    else $error("end flag not cleared by read");
  a_start_busy: assert property (s_start |-> ##[1:2] o_busy)
    else $error("start not taken");
  a_start_modrst: assert property ($rose(o_busy) |-> o_mod_reset)
    else $error("no reset at sequence start");
  a_eoc_valid: assert property ($rose(o_eoc) |-> o_data_valid)
    else $error("result flagged while invalid");
  a_mux_drop: assert property (i_mux_change |=> !o_data_valid)
    else $error("valid kept after select change");
  a_prime_quiet: assert property ($rose(o_busy) |-> s_quiet)
    else $error("result before priming");
endmodule
bind dsac_ctrl dsac_ctrl_props props_u (.*);
`default_nettype wire

// ---- sim/dsac_reader.sv ----
// Reader model: a CPU or DMA channel polling the completion bit.
// Assumes the sequencer clears the bit on the edge that takes the read.
`default_nettype none
module dsac_reader
  import dsac_pkg::*;
(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  // Bench control
  input  wire logic       i_enable,
  input  wire logic [7:0] i_delay,
  // Sequencer side
  input  wire logic       i_status_done,
  output logic            o_read
);
  logic [7:0] wait_q;
  // Polls status instead of the end output; waits i_delay cycles first
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_read <= 1'b0;
      wait_q <= 8'h00;
    end else if (o_read) begin
      o_read <= 1'b0;
      wait_q <= 8'h00;
    end else if (i_enable && i_status_done) begin
      if (wait_q >= i_delay) o_read <= 1'b1;
      else wait_q <= wait_q + 8'h01;
    end else begin
      wait_q <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the conversion sequencer.
// Assumes a 10 MHz clock; turbo above 16 bits is too long to run here.
`default_nettype none
`include "dsac_defines.svh"
module tb
  import dsac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst = 1, en = 0, sb = 0, soc = 0, mb = 0, mux = 0, rd_en = 0;
  logic [7:0] dly = 8'h00;
  dsac_mode_t mode = `DSAC_MODE_SINGLE;
  dsac_res_t  res = `DSAC_RES_MIN;
  dsac_data_t result;
  logic       eoc, done, busy, valid, rd;
  int         bad_count = 0, checks = 0, n, g;
  always #50 clk = ~clk;
  always @(posedge clk) mb <= ~mb;
  dsac_ctrl dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_mode(mode), .i_res(res),
    .i_enable(en), .i_start_bit(sb), .i_soc(soc), .i_mod_bit(mb), .i_mux_change(mux),
    .i_result_read(rd), .o_result(result), .o_eoc(eoc), .o_status_done(done),
    .o_busy(busy), .o_data_valid(valid), .o_mod_reset());
  dsac_reader rd_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_enable(rd_en), .i_delay(dly),
    .i_status_done(done), .o_read(rd));
  task finish_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // Bounded wait for the end flag to reach lvl; counts the cycles spent
  task wait_lvl(input logic lvl, input int lim, output int cyc);
    cyc = 0;
    while (eoc !== lvl && cyc < lim) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    if (cyc >= lim) begin
      bad_count++;
      $display("[FAIL] t=%0t wait=%h exp=%h", $time, eoc, lvl);
      finish_test();
    end
  endtask
  task start(input logic by_input);
    @(posedge clk);
    if (by_input) soc <= 1'b1;
    else sb <= 1'b1;
    @(posedge clk);
    sb <= 1'b0;
    soc <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    en <= 1'b1;
    #1;
    chk(busy, 1'b0);
    chk(eoc, 1'b0);
    start(1'b0);
    wait_lvl(1'b1, 1100, n);
    chk_rng(n, 1020, 1032);
    repeat (20) @(posedge clk);
    #1;
    chk(eoc, 1'b1);
    chk(done, 1'b1);
    rd_en <= 1'b1;
    wait_lvl(1'b0, 10, n);
    repeat (300) @(posedge clk);
    #1;
    chk(busy, 1'b0);
    chk(eoc, 1'b0);
    start(1'b1);
    wait_lvl(1'b1, 1100, n);
    chk_rng(n, 1020, 1032);
    for (int m = 1; m < 4; m++) begin
      wait_lvl(1'b0, 10, n);
      @(posedge clk);
      mode <= dsac_mode_t'(m);
      start(1'b0);
      wait_lvl(1'b1, 1100, n);
      chk_rng(n, 1020, 1032);
      wait_lvl(1'b0, 10, g);
      wait_lvl(1'b1, 1100, n);
      if (m == 1) chk_rng(n + g, 256, 256);
      else chk_rng(n + g, 1024, 1040);
      if (m == 1) begin
        @(posedge clk);
        mux <= 1'b1;
        @(posedge clk);
        mux <= 1'b0;
        #1;
        chk(valid, 1'b0);
        repeat (1100) @(posedge clk);
        #1;
        chk(valid, 1'b1);
      end
      @(posedge clk);
      en <= 1'b0;
      repeat (3) @(posedge clk);
      en <= 1'b1;
      #1;
    end
    finish_test();
  end
endmodule
`default_nettype wire
